/* bth_pkg.sv */
// constants, register map and carrier types of the per-stream prbs tester
package bth_pkg;
  localparam int          NUM_STREAMS     = 32;
  localparam int          PRBS_LEN        = 15;
  localparam logic [14:0] PRBS_SEED       = 15'h7fff;
  localparam logic [3:0]  SYNC_BITS       = 4'hf;
  localparam logic [15:0] ERR_MAX         = 16'hffff;
  // register map on the 14-bit port address
  localparam logic [13:0] ADDR_MODE       = 14'h0001;
  localparam logic [8:0]  GRP_RX_CTRL     = 9'h008;
  localparam logic [8:0]  GRP_RX_START    = 9'h009;
  localparam logic [8:0]  GRP_RX_LEN      = 9'h00a;
  localparam logic [8:0]  GRP_ERR_CNT     = 9'h00b;
  // field positions
  localparam int          MODE_RX_EN_BIT  = 5;
  localparam int          MODE_TX_EN_BIT  = 4;
  localparam int          CTRL_CLEAR_BIT  = 1;
  localparam int          CTRL_ENABLE_BIT = 0;
  localparam int          CM_MODE_BIT     = 0;
  localparam logic [1:0]  CC_PATTERN      = 2'h2;
  // reset values and length limits
  localparam logic [15:0] RST_WORD        = 16'h0000;
  localparam logic [8:0]  MIN_LEN         = 9'h001;
  localparam logic [8:0]  BASE_MAX_LEN    = 9'h020;
  localparam logic [10:0] RST_BITPOS      = 11'h000;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [13:0] addr;
    logic [15:0] wdata;
  } bth_bus_req_t;

  typedef struct packed {
    logic       en;
    logic [7:0] start;
    logic [8:0] len;
  } bth_rx_cfg_t;
endpackage : bth_pkg

/* bth_prbs15.sv */
// one x^15 + x^14 + 1 pattern generator, free running or loaded from received bits
`timescale 1ns/100ps
`default_nettype none
module bth_prbs15 (
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic nrst_in,
  input  wire logic ce_in,
  // control
  input  wire logic step_in,
  input  wire logic load_in,
  input  wire logic data_in,
  // pattern
  output logic      bit_out
);
  logic [14:0] state;

  assign bit_out = state[14] ^ state[13];

  // while loading, received bits replace the feedback so the generator locks on
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= bth_pkg::PRBS_SEED;
    end else if (ce_in && step_in) begin
      state <= {state[13:0], load_in ? data_in : bit_out};
    end
  end
endmodule : bth_prbs15
`default_nettype wire

/* bth_ber_tester.sv */
// per-stream prbs transmitters and error-counting receivers for a 32-stream tdm switch
// Operation
// - one pattern transmitter per output stream, one receiver per input stream, 32 each.
// - transmitters produce a pseudorandom sequence of period 2^15 - 1 bits.
// - pattern may start at any channel, lasting one channel up to one frame.
// - mode register bit 5 enables all receivers, bit 4 all transmitters.
// - after reset every transmitter and receiver is disabled.
// - writing one to control bit 1 clears the stream's error count.
// - control bit 0 enables the stream's receiver and starts comparison.
// - start register bits 7..0 select the first compared input channel.
// - length register bits 8..0 give compared channel count, minimum one.
// - compared length at most 32, 64, 128 or 256 channels by stream rate.
// - error count is read-only and sticks at 0xffff instead of wrapping.
// - each receiver counts bit errors in a 16-bit counter.
// - channel-control field bits 2..1 equal to 10 sources the transmitter; the logic also requires bit 0 set.
`timescale 1ns/100ps
`default_nettype none
module bth_ber_tester (
  // clock, reset, enable
  input  wire logic                 ref_clk_in,
  input  wire logic                 nrst_in,
  input  wire logic                 ce_in,
  // register port
  input  wire bth_pkg::bth_bus_req_t bus_req_in,
  output logic [15:0]               rdata_out,
  // switch timing
  input  wire logic                 frame_start_in,
  input  wire logic [31:0]          rx_bit_tick_in,
  input  wire logic [63:0]          rx_rate_in,
  input  wire logic [31:0]          tx_bit_tick_in,
  // input stream pins
  input  wire logic [31:0]          rx_stream_in,
  // current connection-memory low entry per output stream, bits 2..0
  input  wire logic [95:0]          cm_entry_in,
  // pattern toward the output streams
  output logic [31:0]               tx_select_out,
  output logic [31:0]               tx_bit_out
);
  logic              all_receivers_enable;
  logic              all_transmitters_enable;
  logic [31:0]       rx_meta;
  logic [31:0]       rx_sync;
  logic              hit_mode;
  logic              hit_stream;
  logic [8:0]        grp;
  logic [4:0]        idx;
  logic [15:0]       err_word   [bth_pkg::NUM_STREAMS];
  bth_pkg::bth_rx_cfg_t cfg_word [bth_pkg::NUM_STREAMS];

  assign grp        = bus_req_in.addr[13:5];
  assign idx        = bus_req_in.addr[4:0];
  assign hit_mode   = (bus_req_in.addr == bth_pkg::ADDR_MODE);
  assign hit_stream = (grp == bth_pkg::GRP_RX_CTRL) || (grp == bth_pkg::GRP_RX_START) ||
                      (grp == bth_pkg::GRP_RX_LEN) || (grp == bth_pkg::GRP_ERR_CNT);

  // input pins cross into the clock domain through two stages
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_meta <= 32'h0000_0000;
      rx_sync <= 32'h0000_0000;
    end else if (ce_in) begin
      rx_meta <= rx_stream_in;
      rx_sync <= rx_meta;
    end
  end

  // global enables, both off after reset
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      all_receivers_enable    <= 1'b0;
      all_transmitters_enable <= 1'b0;
    end else if (ce_in && bus_req_in.wr && hit_mode) begin
      all_receivers_enable    <= bus_req_in.wdata[bth_pkg::MODE_RX_EN_BIT];
      all_transmitters_enable <= bus_req_in.wdata[bth_pkg::MODE_TX_EN_BIT];
    end
  end

  // read data is registered; unmapped addresses read zero
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= bth_pkg::RST_WORD;
    end else if (ce_in && bus_req_in.rd) begin
      if (hit_mode) begin
        rdata_out <= {10'h000, all_receivers_enable, all_transmitters_enable, 4'h0};
      end else begin
        case (grp)
          bth_pkg::GRP_RX_CTRL:  rdata_out <= {15'h0000, cfg_word[idx].en};
          bth_pkg::GRP_RX_START: rdata_out <= {8'h00, cfg_word[idx].start};
          bth_pkg::GRP_RX_LEN:   rdata_out <= {7'h00, cfg_word[idx].len};
          bth_pkg::GRP_ERR_CNT:  rdata_out <= err_word[idx];
          default:               rdata_out <= bth_pkg::RST_WORD;
        endcase
      end
    end
  end

  genvar n;
  generate
    for (n = 0; n < bth_pkg::NUM_STREAMS; n++) begin : g_stream
      logic       wr_here;
      logic [1:0] cc;
      logic       tx_on;
      logic       tx_step;
      logic       tx_pat;
      logic       tx_sel_q;
      logic       tx_bit_q;
      bth_pkg::bth_rx_cfg_t cfg;
      logic       clr_req;
      logic       rx_on;
      logic [10:0] bitpos;
      logic [10:0] cur_pos;
      logic [7:0] ch;
      logic [8:0] offs;
      logic [8:0] max_len;
      logic [8:0] want_len;
      logic [8:0] eff_len;
      logic       in_window;
      logic       rx_step;
      logic [3:0] sync_cnt;
      logic       synced;
      logic       rx_pat;
      logic       mismatch;
      logic [15:0] err_cnt;
      logic [15:0] next_err_cnt;

      assign wr_here = ce_in && bus_req_in.wr && hit_stream && (idx == 5'(n));

      // transmitter: sourced only where the connection entry selects the pattern
      assign cc      = cm_entry_in[3*n+2 -: 2];
      assign tx_on   = all_transmitters_enable && cm_entry_in[3*n + bth_pkg::CM_MODE_BIT] &&
                       (cc == bth_pkg::CC_PATTERN);
      assign tx_step = tx_on && tx_bit_tick_in[n];

      bth_prbs15 u_tx_gen (
        .ref_clk_in (ref_clk_in),
        .nrst_in    (nrst_in),
        .ce_in      (ce_in),
        .step_in    (tx_step),
        .load_in    (1'b0),
        .data_in    (1'b0),
        .bit_out    (tx_pat)
      );

      always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          tx_sel_q <= 1'b0;
          tx_bit_q <= 1'b0;
        end else if (ce_in) begin
          tx_sel_q <= tx_on;
          tx_bit_q <= tx_on ? tx_pat : 1'b0;
        end
      end

      assign tx_select_out[n] = tx_sel_q;
      assign tx_bit_out[n]    = tx_bit_q;

      // receiver configuration; clear is a write-one pulse, never stored
      always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          cfg     <= '0;
          clr_req <= 1'b0;
        end else if (ce_in) begin
          clr_req <= wr_here && (grp == bth_pkg::GRP_RX_CTRL) &&
                     bus_req_in.wdata[bth_pkg::CTRL_CLEAR_BIT];
          if (wr_here && grp == bth_pkg::GRP_RX_CTRL) begin
            cfg.en <= bus_req_in.wdata[bth_pkg::CTRL_ENABLE_BIT];
          end
          if (wr_here && grp == bth_pkg::GRP_RX_START) begin
            cfg.start <= bus_req_in.wdata[7:0];
          end
          if (wr_here && grp == bth_pkg::GRP_RX_LEN) begin
            cfg.len <= bus_req_in.wdata[8:0];
          end
        end
      end

      assign cfg_word[n] = cfg;
      assign rx_on       = all_receivers_enable && cfg.en;

      // bit position in the frame; the frame pulse marks bit zero
      assign cur_pos = frame_start_in ? bth_pkg::RST_BITPOS : bitpos;
      always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          bitpos <= bth_pkg::RST_BITPOS;
        end else if (ce_in && rx_bit_tick_in[n]) begin
          bitpos <= cur_pos + 11'h001;
        end else if (ce_in && frame_start_in) begin
          bitpos <= bth_pkg::RST_BITPOS;
        end
      end

      // compared window clamped to one channel minimum and the rate's frame size
      assign ch        = cur_pos[10:3];
      assign offs      = {1'b0, ch} - {1'b0, cfg.start};
      assign max_len   = bth_pkg::BASE_MAX_LEN << rx_rate_in[2*n +: 2];
      assign want_len  = (cfg.len == 9'h000) ? bth_pkg::MIN_LEN : cfg.len;
      assign eff_len   = (want_len > max_len) ? max_len : want_len;
      assign in_window = (ch >= cfg.start) && (offs < eff_len);
      assign rx_step   = rx_on && rx_bit_tick_in[n] && in_window;

      // the local generator loads the first 15 received bits, then runs free
      assign synced = (sync_cnt == bth_pkg::SYNC_BITS);
      always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          sync_cnt <= 4'h0;
        end else if (ce_in) begin
          if (!rx_on) begin
            sync_cnt <= 4'h0;
          end else if (rx_step && !synced) begin
            sync_cnt <= sync_cnt + 4'h1;
          end
        end
      end

      bth_prbs15 u_rx_gen (
        .ref_clk_in (ref_clk_in),
        .nrst_in    (nrst_in),
        .ce_in      (ce_in),
        .step_in    (rx_step),
        .load_in    (!synced),
        .data_in    (rx_sync[n]),
        .bit_out    (rx_pat)
      );

      assign mismatch = rx_step && synced && (rx_pat != rx_sync[n]);

      // saturating count; an error in the clearing cycle still counts as one
      always_comb begin
        next_err_cnt = err_cnt;
        if (clr_req) begin
          next_err_cnt = mismatch ? 16'h0001 : bth_pkg::RST_WORD;
        end else if (mismatch && err_cnt != bth_pkg::ERR_MAX) begin
          next_err_cnt = err_cnt + 16'h0001;
        end
      end

      always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          err_cnt <= bth_pkg::RST_WORD;
        end else if (ce_in) begin
          err_cnt <= next_err_cnt;
        end
      end

      assign err_word[n] = err_cnt;
    end
  endgenerate
endmodule : bth_ber_tester
`default_nettype wire

/* bth_ber_asserts.sv */
// port assertions for the prbs tester
`timescale 1ns/100ps
`default_nettype none
module bth_ber_asserts (
  // clock and reset
  input wire logic                  ref_clk_in,
  input wire logic                  nrst_in,
  // watched ports
  input wire logic                  ce_in,
  input wire bth_pkg::bth_bus_req_t bus_req_in,
  input wire logic [15:0]           rdata_out,
  input wire logic [95:0]           cm_entry_in,
  input wire logic [31:0]           tx_select_out,
  input wire logic [31:0]           tx_bit_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  logic       rd_ok;
  logic [8:0] grp;
  assign rd_ok = bus_req_in.rd && ce_in;
  assign grp   = bus_req_in.addr[13:5];
  property p_mode_rd;
    rd_ok && bus_req_in.addr == bth_pkg::ADDR_MODE |=> {rdata_out[15:6], rdata_out[3:0]} == 14'h0000;
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode read spare bits set");
  property p_ctrl_rd;
    rd_ok && grp == bth_pkg::GRP_RX_CTRL |=> rdata_out[15:1] == 15'h0000;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read upper bits set");
  property p_start_rd;
    rd_ok && grp == bth_pkg::GRP_RX_START |=> rdata_out[15:8] == 8'h00;
  endproperty
  a_start_rd: assert property (p_start_rd) else $error("start read too wide");
  property p_len_rd;
    rd_ok && grp == bth_pkg::GRP_RX_LEN |=> rdata_out[15:9] == 7'h00;
  endproperty
  a_len_rd: assert property (p_len_rd) else $error("length read too wide");
  property p_rst;
    !$past(nrst_in) |-> tx_select_out == 32'h00000000 && rdata_out == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  property p_sel0;
    tx_select_out[0] && $past(ce_in) |-> $past(cm_entry_in[2:0]) == 3'h5;
  endproperty
  a_sel0: assert property (p_sel0) else $error("stream 0 selected without pattern code");
  property p_sel31;
    tx_select_out[31] && $past(ce_in) |-> $past(cm_entry_in[95:93]) == 3'h5;
  endproperty
  a_sel31: assert property (p_sel31) else $error("stream 31 selected without pattern code");
  property p_bit_gate;
    (tx_bit_out & ~tx_select_out) == 32'h00000000;
  endproperty
  a_bit_gate: assert property (p_bit_gate) else $error("pattern bit on unselected stream");
endmodule : bth_ber_asserts
bind bth_ber_tester bth_ber_asserts u_chk (.ref_clk_in, .nrst_in, .ce_in, .bus_req_in, .rdata_out, .cm_entry_in,
  .tx_select_out, .tx_bit_out);
`default_nettype wire

/* bth_peer_model.sv */
// far-end framer model: frame timing and a pattern in a channel window
`timescale 1ns/100ps
`default_nettype none
module bth_peer_model (
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       nrst_in,
  // window and fault control
  input  wire logic [7:0] start_in,
  input  wire logic [8:0] len_in,
  input  wire logic       flip_in,
  // stream toward the tester
  output logic            pin_out,
  output logic            frame_start_out
);
  logic [10:0] pos;
  logic [14:0] lfsr;
  logic        bad_frame;
  logic        in_win;
  logic        next_bit;
  logic [9:0]  ch;
  assign ch = {2'h0, pos[10:3]};
  // one unbroken run of channels, as long as the receiver length
  assign in_win   = ch >= {2'h0, start_in} && ch < {2'h0, start_in} + {1'b0, len_in};
  assign next_bit = lfsr[14] ^ lfsr[13];
  // outside the window the line carries other traffic, never idle
  assign pin_out  = in_win ? next_bit ^ bad_frame : pos[0];
  // pin sync costs two edges, so the frame mark trails bit 0 by two
  assign frame_start_out = pos == 11'h002;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pos       <= 11'h000;
      lfsr      <= 15'h1234;
      bad_frame <= 1'b0;
    end else begin
      pos <= pos + 11'h001;
      if (in_win) begin
        lfsr <= {lfsr[13:0], next_bit};
      end
      if (pos == 11'h7ff) begin
        bad_frame <= flip_in;
      end
    end
  end
endmodule : bth_peer_model
`default_nettype wire

/* bth_ber_tester_test.sv */
// self-checking bench for the prbs tester
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module bth_ber_tester_test;
  logic                  clk = 1'b0;
  logic                  nrst = 1'b0;
  bth_pkg::bth_bus_req_t req = '0;
  logic [95:0]           cm = '0;
  logic [31:0]           txt = '0;
  logic [7:0]            pst = 8'h00;
  logic [8:0]            pln = 9'h001;
  logic                  flip = 1'b0;
  logic [63:0]           rte = '0;
  logic [15:0]           rdata;
  logic [31:0]           tsel;
  logic [31:0]           tbit;
  logic                  pin;
  logic                  fs;
  logic [15:0]           v;
  logic [39:0]           seq;
  int                    err_total = 0;
  int                    n_compared = 0;
  bth_ber_tester u_dut (.ref_clk_in(clk), .nrst_in(nrst), .ce_in(1'b1), .bus_req_in(req), .rdata_out(rdata),
    .frame_start_in(fs), .rx_bit_tick_in(32'hffffffff), .rx_rate_in(rte), .tx_bit_tick_in(txt),
    .rx_stream_in({32{pin}}), .cm_entry_in(cm), .tx_select_out(tsel), .tx_bit_out(tbit));
  bth_peer_model u_peer (.ref_clk_in(clk), .nrst_in(nrst), .start_in(pst), .len_in(pln), .flip_in(flip),
    .pin_out(pin), .frame_start_out(fs));
  initial forever #25 clk = ~clk;
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  task automatic bus(input logic w, input logic [13:0] a, input logic [15:0] d);
    @(posedge clk) #1;
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk) #1;
    req = '0;
    v = rdata;
  endtask : bus
  task automatic rd_chk(input logic [13:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    `CHK($sformatf("reg %h", a), e, v)
  endtask : rd_chk
  task automatic frames(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin @(posedge clk) #1; k++; end while (fs !== 1'b1 && k < 3000);
      if (fs !== 1'b1) begin
        err_total++;
        close_out();
      end
    end
  endtask : frames
  // errors land in whole frames, so the count is exact
  task automatic corrupt(input int n);
    frames(1);
    flip = 1'b1;
    frames(n);
    flip = 1'b0;
    frames(1);
  endtask : corrupt
  initial begin
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    cm = {32{3'h5}};
    txt = '1;
    repeat (2) @(posedge clk);
    #1 `CHK("select off", 32'h0, tsel)
    rd_chk(14'h0001, 16'h0000);
    rd_chk(14'h0100, 16'h0000);
    rd_chk(14'h0160, 16'h0000);
    bus(1'b1, 14'h0160, 16'h1234);
    rd_chk(14'h0160, 16'h0000);
    bus(1'b1, 14'h0001, 16'hffff);
    rd_chk(14'h0001, 16'h0030);
    for (int c = 0; c < 8; c++) begin
      cm = {32{c[2:0]}};
      repeat (2) @(posedge clk);
      #1 `CHK("select", (c == 5) ? 32'hffffffff : 32'h0, tsel)
    end
    cm = {32{3'h5}};
    repeat (2) @(posedge clk);
    for (int i = 0; i < 40; i++) @(negedge clk) seq[i] = tbit[0];
    for (int i = 15; i < 40; i++) `CHK("tx bit", seq[i-14] ^ seq[i-15], seq[i])
    `CHK("tx live", 1'b1, |seq)
    bus(1'b1, 14'h0120, 16'hffff);
    rd_chk(14'h0120, 16'h00ff);
    pst = 8'h03;
    pln = 9'h002;
    bus(1'b1, 14'h0120, 16'h0003);
    bus(1'b1, 14'h0140, 16'h0002);
    rd_chk(14'h0140, 16'h0002);
    frames(2);
    bus(1'b1, 14'h0100, 16'h0003);
    rd_chk(14'h0100, 16'h0001);
    frames(2);
    rd_chk(14'h0160, 16'h0000);
    corrupt(1);
    rd_chk(14'h0160, 16'h0010);
    bus(1'b1, 14'h0100, 16'h0003);
    rd_chk(14'h0160, 16'h0000);
    bus(1'b1, 14'h0100, 16'h0000);
    pst = 8'h00;
    pln = 9'h100;
    rte = {32{2'h3}};
    bus(1'b1, 14'h0120, 16'h0000);
    bus(1'b1, 14'h0140, 16'h0100);
    bus(1'b1, 14'h0100, 16'h0003);
    // 32 full frames give 65536 errors, one past the top
    corrupt(32);
    rd_chk(14'h0160, 16'hffff);
    close_out();
  end
endmodule : bth_ber_tester_test
`default_nettype wire
